/* File: logic/wdog_pkg.sv */
`default_nettype none
package wdog_pkg;

	// Register byte offsets
	localparam logic [11:0] CONFIG_OFFSET = 12'h034;
	localparam logic [11:0] CODE_OFFSET   = 12'h038;
	localparam logic [11:0] STATUS_OFFSET = 12'h03c;
	localparam logic [11:0] CLEAR_OFFSET  = 12'h040;
	localparam logic [11:0] ENABLE_OFFSET = 12'h044;
	localparam logic [11:0] STATE_OFFSET  = 12'h048;

	// Configuration register fields
	localparam int ACTION_BIT     = 0;
	localparam int PERIOD_LSB     = 1;
	localparam int PERIOD_MSB     = 2;
	localparam int RUN_BIT        = 3;

	// Reset values of the configuration fields
	localparam logic       RUN_RESET    = 1'h1;
	localparam logic [1:0] PERIOD_RESET = 2'h0;
	localparam logic       ACTION_RESET = 1'h1;

	// Code register values
	localparam logic [7:0] CLEAR_CODE   = 8'h4e;
	localparam logic [7:0] DISABLE_CODE = 8'hb1;

	// Status, clear and enable bits
	localparam int STAT_W        = 2;
	localparam int STAT_INT_BIT  = 0;
	localparam int STAT_RST_BIT  = 1;

	// Readback state register fields
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_ACTION_BIT = 1;
	localparam int ST_PERIOD_LSB = 2;
	localparam int ST_RUN_BIT    = 4;
	localparam int ST_BIN_LSB    = 5;
	localparam int ST_RESET_BIT  = 7;

	// Divider chain: quarter-period taps per source
	localparam int          DIV_W       = 23;
	localparam logic [4:0]  HF_TAP_BASE = 5'h17;
	localparam logic [4:0]  LF_TAP_BASE = 5'h0f;
	localparam logic [1:0]  BIN_LAST    = 2'h3;

	// AHB encodings
	localparam logic [2:0]  SIZE_WORD   = 3'h2;
	localparam logic        RESP_OKAY   = 1'h0;

	// Reset request length: 24 high-frequency periods
	localparam int CLK_PERIOD_NS  = 10;
	localparam int HF_PERIOD_PS   = 62500;
	localparam int RST_HF_PERIODS = 24;
	localparam int RST_TIME_NS    = RST_HF_PERIODS * HF_PERIOD_PS / 1000;
	localparam int RST_CYCLES_RAW = RST_TIME_NS / CLK_PERIOD_NS;
	localparam int RST_CYCLES     = (RST_CYCLES_RAW < 1) ? 1 : RST_CYCLES_RAW;
	localparam int RST_CNT_W      = 8;

	typedef enum logic [0:0] {
		PHASE_COUNT,
		PHASE_RESET
	} phase_type;

endpackage : wdog_pkg
`default_nettype wire

/* File: logic/tick_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      tick
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic tick;
	} sync_state_type;

	sync_state_type s_reg;
	sync_state_type s_next;

	// Edge detect reads the second stage and its delayed copy in the third
	always_comb begin
		s_next      = s_reg;
		s_next.meta = pin;
		s_next.sync = s_reg.meta;
		s_next.prev = s_reg.sync;
		s_next.tick = s_reg.sync & ~s_reg.prev;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;

endmodule : tick_sync
`default_nettype wire

/* File: logic/wdog_timer_control.sv */
// Behaviour
// - After reset: running, run bit 1, reset action, period selector 00.
// - Unclearned counter overflow raises reset request or watchdog interrupt by action bit.
// - Count pauses in stop, idle and sleep modes; resumes from held value.
// - Divider feeds two-stage binary counter; clear code clears only binary counter.
// - Divider not cleared, so first overflow may come at three quarters of period.
// - Selector picks 2^25..2^19 fast periods or 2^17..2^11 slow periods.
// - Interrupt action, once written, cannot return to reset action until reset.
// - Configuration register is write-only, reads undefined; no read-modify-write.
// - Disable code stops watchdog only while run bit holds 0.
// - While disabled the binary counter is held cleared.
// - Watchdog interrupt is non-maskable and taken even during other service.
// - Watchdog reset request resets hardware, lasting at most 24 fast periods.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_control (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	input  wire logic        HF_CLK_PIN,
	input  wire logic        LF_CLK_PIN,
	input  wire logic        SLOW_MODE,
	input  wire logic        DIVIDER_TAP_SEL,
	input  wire logic        STOP_MODE,
	input  wire logic        IDLE_MODE,
	input  wire logic        SLEEP_MODE,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             WDOG_RESET_REQ,
	output logic             WDOG_IRQ,
	output logic             IRQ
);

	// Block state apart from the pin synchronisers; one register holds all of it
	typedef struct packed {
		wdog_pkg::phase_type                 phase;
		logic [wdog_pkg::DIV_W-1:0]          div;
		logic [1:0]                          bin;
		logic                                active;
		logic                                run_bit;
		logic [1:0]                          period_sel;
		logic                                action_sel;
		logic [wdog_pkg::RST_CNT_W-1:0]      rst_cnt;
		logic                                ap_valid;
		logic                                ap_write;
		logic [11:0]                         ap_addr;
		logic [wdog_pkg::STAT_W-1:0]         status;
		logic [wdog_pkg::STAT_W-1:0]         irq_en;
		logic [31:0]                         rdata;
		logic                                ready;
		logic                                rst_req;
		logic                                nmi;
		logic                                irq;
	} state_type;

	// Reset counter load: request length in system cycles minus one
	// Rounded down so the request never outlasts its bound
	localparam logic [wdog_pkg::RST_CNT_W-1:0] RST_LOAD = wdog_pkg::RST_CNT_W'(wdog_pkg::RST_CYCLES - 1);

	// Reset image of the whole state
	localparam state_type RESET_STATE = '{
		phase:      wdog_pkg::PHASE_COUNT,
		div:        '0,
		bin:        '0,
		active:     1'h1,
		run_bit:    wdog_pkg::RUN_RESET,
		period_sel: wdog_pkg::PERIOD_RESET,
		action_sel: wdog_pkg::ACTION_RESET,
		rst_cnt:    '0,
		ap_valid:   1'h0,
		ap_write:   1'h0,
		ap_addr:    '0,
		status:     '0,
		irq_en:     '0,
		rdata:      '0,
		ready:      1'h1,
		rst_req:    1'h0,
		nmi:        1'h0,
		irq:        1'h0
	};

	// Present and next state
	state_type s_reg;
	state_type s_next;

	// Synchronised source clock edges
	logic hf_tick;
	logic lf_tick;

	// Slow clock pins are synchronised and turned into edge pulses
	// Limitation: a pin must stay in each level for one clock or edges are lost
	tick_sync hf_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.pin   (HF_CLK_PIN),
		.tick  (hf_tick)
	);

	tick_sync lf_sync (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.pin   (LF_CLK_PIN),
		.tick  (lf_tick)
	);

	// Quarter-period tap mask for the selected source and period
	// Each selector step shortens the quarter by two divider bits
	function automatic logic [wdog_pkg::DIV_W-1:0] tap_mask(input logic use_lf, input logic [1:0] sel);
		logic [4:0] base;
		logic [4:0] width;
		base  = use_lf ? wdog_pkg::LF_TAP_BASE : wdog_pkg::HF_TAP_BASE;
		width = base - {2'h0, sel, 1'h0};
		tap_mask = wdog_pkg::DIV_W'((33'h1 << width) - 33'h1);
	endfunction : tap_mask

	// Helpers of the next-state process
	logic                         use_lf;
	logic                         src_tick;
	logic                         pause;
	logic                         quarter;
	logic                         wr;
	logic                         clear_hit;
	logic                         overflow;
	logic [7:0]                   wbyte;
	logic [wdog_pkg::DIV_W-1:0]   mask;
	logic [wdog_pkg::STAT_W-1:0]  stat_set;

	// Next-state logic
	// One process computes every field of the next state
	always_comb begin
		// Defaults: state holds unless an event changes it
		s_next    = s_reg;
		s_next.nmi = 1'h0;
		clear_hit = 1'h0;
		overflow  = 1'h0;
		stat_set  = '0;
		// Config and code use only the low byte
		wbyte     = HWDATA[7:0];

		// Clock source choice
		// source and tap
		// Slow mode or the tap select picks the low-frequency source
		use_lf   = SLOW_MODE | DIVIDER_TAP_SEL;
		src_tick = use_lf ? lf_tick : hf_tick;
		mask     = tap_mask(use_lf, s_reg.period_sel);

		// pause in low-power modes
		// Holding both stages resumes from the held value
		pause    = STOP_MODE | IDLE_MODE | SLEEP_MODE;
		quarter  = ~pause & src_tick & ((s_reg.div & mask) == mask);

		// free-running divider
		// Never cleared by software, so the overflow phase drifts
		if (!pause && src_tick) begin
			s_next.div = s_reg.div + 1'h1;
		end

		// Address phase capture; zero wait states
		s_next.ap_valid = HSEL & HREADY & HTRANS[1];
		s_next.ap_write = HWRITE & (HSIZE == wdog_pkg::SIZE_WORD);
		s_next.ap_addr  = HADDR[11:0];

		// The slave never stalls, so ready stays high
		s_next.ready    = 1'h1;

		// Read data registered for the data phase
		// Zero outside the data phase, so a stale value never leaks
		// configuration reads as zero
		// Write-only registers hide their contents
		s_next.rdata = '0;
		if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
			unique case (HADDR[11:0])
				wdog_pkg::STATUS_OFFSET: s_next.rdata = 32'(s_reg.status);
				wdog_pkg::ENABLE_OFFSET: s_next.rdata = 32'(s_reg.irq_en);
				wdog_pkg::STATE_OFFSET: begin
					s_next.rdata[wdog_pkg::ST_ACTIVE_BIT]                    = s_reg.active;
					s_next.rdata[wdog_pkg::ST_ACTION_BIT]                    = s_reg.action_sel;
					s_next.rdata[wdog_pkg::ST_PERIOD_LSB+:2]                 = s_reg.period_sel;
					s_next.rdata[wdog_pkg::ST_RUN_BIT]                       = s_reg.run_bit;
					s_next.rdata[wdog_pkg::ST_BIN_LSB+:2]                    = s_reg.bin;
					s_next.rdata[wdog_pkg::ST_RESET_BIT]                     = (s_reg.phase == wdog_pkg::PHASE_RESET);
				end
				default: s_next.rdata = '0;
			endcase
		end

		// Data phase writes
		// Address captured last cycle, data on the bus now
		wr = s_reg.ap_valid & s_reg.ap_write;
		if (wr) begin
			unique case (s_reg.ap_addr)
				wdog_pkg::CONFIG_OFFSET: begin
					s_next.run_bit    = wbyte[wdog_pkg::RUN_BIT];
					s_next.period_sel = wbyte[wdog_pkg::PERIOD_MSB:wdog_pkg::PERIOD_LSB];
					s_next.action_sel = s_reg.action_sel & wbyte[wdog_pkg::ACTION_BIT];
					// A run bit of 1 re-enables at once
					if (wbyte[wdog_pkg::RUN_BIT]) begin
						s_next.active = 1'h1;
					end
				end
				wdog_pkg::CODE_OFFSET: begin
					if (wbyte == wdog_pkg::CLEAR_CODE) begin
						clear_hit = 1'h1;
					end else if (wbyte == wdog_pkg::DISABLE_CODE && !s_reg.run_bit) begin
						// disable needs run bit 0
						// Run bit set: the code is not a disable
						s_next.active = 1'h0;
					end
				end
				// Write one to clear; a same-cycle set still wins below
				wdog_pkg::CLEAR_OFFSET: s_next.status = s_reg.status & ~HWDATA[wdog_pkg::STAT_W-1:0];
				wdog_pkg::ENABLE_OFFSET: s_next.irq_en = HWDATA[wdog_pkg::STAT_W-1:0];
				default: s_next.status = s_reg.status;
			endcase
		end

		// Binary counter and overflow
		// The divider is never touched here, only the two-bit stage
		unique case (s_reg.phase)
			wdog_pkg::PHASE_COUNT: begin
				if (!s_reg.active || clear_hit) begin
					// held clear when disabled
					// A clear code wins over a quarter tick in the same cycle
					// clear hits binary stage only
					s_next.bin = '0;
				end else if (quarter) begin
					// divider phase kept across clears
					// Overflow only on a quarter tick with the counter at three
					s_next.bin = s_reg.bin + 1'h1;
					overflow   = (s_reg.bin == wdog_pkg::BIN_LAST);
				end
				if (overflow) begin
					if (s_reg.action_sel) begin
						s_next.phase   = wdog_pkg::PHASE_RESET;
						s_next.rst_cnt = RST_LOAD;
						stat_set[wdog_pkg::STAT_RST_BIT] = 1'h1;
					end else begin
						// non-maskable, no gating
						// Enable register gates only IRQ, never this pulse
						// one-cycle request
						s_next.nmi = 1'h1;
						stat_set[wdog_pkg::STAT_INT_BIT] = 1'h1;
					end
				end
			end
			wdog_pkg::PHASE_RESET: begin
				// bounded reset request
				// Counter held so the request cannot retrigger
				s_next.bin = '0;
				if (s_reg.rst_cnt == '0) begin
					s_next.phase = wdog_pkg::PHASE_COUNT;
				end else begin
					s_next.rst_cnt = s_reg.rst_cnt - 1'h1;
				end
			end
		endcase

		// Set beats a same-cycle clear
		// Request and interrupt level are registered from the next state
		s_next.status  = s_next.status | stat_set;
		s_next.rst_req = (s_next.phase == wdog_pkg::PHASE_RESET);
		s_next.irq     = |(s_next.status & s_next.irq_en);
	end

	// reset image
	// Reset branch loads constants only
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s_reg <= RESET_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs other than HRESP straight from the state register
	// No logic between a flop and a pin
	assign HRDATA         = s_reg.rdata;
	assign HREADYOUT      = s_reg.ready;
	// No error response exists, so every transfer is OKAY
	assign HRESP          = wdog_pkg::RESP_OKAY;
	assign WDOG_RESET_REQ = s_reg.rst_req;
	assign WDOG_IRQ       = s_reg.nmi;
	assign IRQ            = s_reg.irq;

endmodule : wdog_timer_control
`default_nettype wire

/* File: tb/wdog_timer_control_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_control_monitor (
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic        STOP_MODE,
	input wire logic        IDLE_MODE,
	input wire logic        SLEEP_MODE,
	input wire logic [31:0] HRDATA,
	input wire logic        WDOG_RESET_REQ,
	input wire logic        WDOG_IRQ
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [7:0] hi_cnt;
	logic       pause;
	// Any pause mode freezes the chain
	assign pause = STOP_MODE | IDLE_MODE | SLEEP_MODE;
	// Cycles the reset request has stood so far
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			hi_cnt <= 8'h00;
		else
			hi_cnt <= WDOG_RESET_REQ ? hi_cnt + 8'h01 : 8'h00;
	end
	property p_irq_pulse;
		$rose(WDOG_IRQ) |=> !WDOG_IRQ [*8];
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
	property p_rst_hold;
		$rose(WDOG_RESET_REQ) |=> WDOG_RESET_REQ [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset request too short");
	property p_rst_len;
		$fell(WDOG_RESET_REQ) |-> hi_cnt == wdog_pkg::RST_CYCLES;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset request length wrong");
	property p_rst_max;
		WDOG_RESET_REQ |-> hi_cnt < wdog_pkg::RST_CYCLES;
	endproperty
	a_rst_max: assert property (p_rst_max) else $error("reset request overlong");
	property p_one_kind;
		!(WDOG_IRQ && WDOG_RESET_REQ);
	endproperty
	a_one_kind: assert property (p_one_kind) else $error("both overflow actions");
	property p_pause;
		pause [*2] |-> !$rose(WDOG_IRQ) && !$rose(WDOG_RESET_REQ);
	endproperty
	a_pause: assert property (p_pause) else $error("overflow while paused");
	property p_cfg_read;
		HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[11:0] == wdog_pkg::CONFIG_OFFSET |=> HRDATA == 32'h0;
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config read not zero");
	property p_quiet;
		$rose(RST_N) |-> !WDOG_RESET_REQ [*8];
	endproperty
	a_quiet: assert property (p_quiet) else $error("request right after reset");
endmodule : wdog_timer_control_monitor
`default_nettype wire

/* File: tb/wdog_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module wdog_partner (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic irq_flag,
	input  wire logic wirq,
	input  wire logic req,
	output var int    taken,
	output var int    resets
);
	logic req_d;
	always @(posedge clk) begin
		req_d <= req;
		if (!rst_n) begin
			taken <= 0;
			resets <= 0;
		end else begin
			taken <= taken + ((wirq === 1'b1 && (irq_flag | !irq_flag)) ? 1 : 0);
			resets <= resets + ((req === 1'b1 && req_d !== 1'b1) ? 1 : 0);
		end
	end
endmodule : wdog_partner
`default_nettype wire

/* File: tb/wdog_timer_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module wdog_timer_control_test;
	logic        clk, rst_n, hsel, hwrite, lf, hf, slow, tap, stp, idl, slp, mif;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        hrdy, hresp, req, wirq, irq;
	int          failures, comparisons, cyc, n, ntaken, nres, seed, e_act, e_per, e_run, e_on;
	wdog_timer_control u_dut (.CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HF_CLK_PIN(hf), .LF_CLK_PIN(lf),
		.SLOW_MODE(slow), .DIVIDER_TAP_SEL(tap), .STOP_MODE(stp), .IDLE_MODE(idl), .SLEEP_MODE(slp),
		.HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .WDOG_RESET_REQ(req), .WDOG_IRQ(wirq), .IRQ(irq));
	wdog_partner u_cpu (.clk(clk), .rst_n(rst_n), .irq_flag(mif), .wirq(wirq), .req(req), .taken(ntaken),
		.resets(nres));
	// Clock, oscillator pins toggled fast to keep periods short
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		lf <= ~lf;
		hf <= ~hf;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			final_report();
		end
	end
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic check_in(input string nm, input int lo, input int hi, input int g);
		comparisons++;
		if (g < lo || g > hi) begin
			failures++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : check_in
	// One single word transfer, zero or more wait states
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= wdog_pkg::SIZE_WORD;
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wait_for(input logic rst, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((rst ? req : wirq) !== 1'b1 && n < lim);
	endtask : wait_for
	task automatic chk_state;
		bus(1'b0, wdog_pkg::STATE_OFFSET, 32'h0);
		check("state", {e_run[0], e_per[1:0], e_act[0], e_on[0]}, {27'h0, rd[4:0]});
		check("resp", 32'h0, {31'h0, hresp});
	endtask : chk_state
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	initial begin
		{hsel, hwrite, lf, hf, slow, tap, stp, idl, slp, mif, htrans, hsize} = '0;
		{haddr, hwdata, cyc, failures, comparisons} = '0;
		seed = 32'h8f66;
		{e_act, e_per, e_run, e_on} = {1, 0, 1, 1};
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_state();
		bus(1'b1, wdog_pkg::ENABLE_OFFSET, 32'h1);
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
		bus(1'b1, wdog_pkg::CONFIG_OFFSET, 32'h0e);
		{e_act, e_per} = {0, 3};
		tap <= 1'b1;
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
		wait_for(1'b0, 5000);
		check_in("irq delay", 3060, 4110, n);
		repeat (2) @(posedge clk);
		check("taken", 1, ntaken);
		bus(1'b0, wdog_pkg::STATUS_OFFSET, 32'h0);
		check("status", 32'h1, {30'h0, rd[1:0]});
		check("irq", 32'h1, {31'h0, irq});
		bus(1'b1, wdog_pkg::ENABLE_OFFSET, 32'h0);
		repeat (2) @(posedge clk);
		check("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, wdog_pkg::ENABLE_OFFSET, 32'h1);
		bus(1'b1, wdog_pkg::CLEAR_OFFSET, 32'h1);
		repeat (2) @(posedge clk);
		check("irq cleared", 32'h0, {31'h0, irq});
		bus(1'b1, wdog_pkg::CONFIG_OFFSET, 32'h0f);
		chk_state();
		check("bin after irq", 32'h0, {30'h0, rd[6:5]});
		bus(1'b0, wdog_pkg::CONFIG_OFFSET, 32'h0);
		check("config read", 32'h0, rd);
		$display("test overflow interrupt done");
		repeat (4) begin
			bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
			repeat (2000) @(posedge clk);
		end
		check("taken", 1, ntaken);
		n = $random(seed);
		if (n[7:0] == wdog_pkg::CLEAR_CODE || n[7:0] == wdog_pkg::DISABLE_CODE)
			n = 0;
		bus(1'b1, wdog_pkg::CODE_OFFSET, {24'h0, n[7:0]});
		wait_for(1'b0, 5000);
		check_in("junk code", 1050, 2120, n);
		$display("test clearing done");
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::DISABLE_CODE);
		chk_state();
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
		bus(1'b1, wdog_pkg::CONFIG_OFFSET, 32'h06);
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::DISABLE_CODE);
		{e_run, e_on} = {0, 0};
		chk_state();
		check("bin", 32'h0, {30'h0, rd[6:5]});
		wait_for(1'b0, 5000);
		check_in("disabled", 5000, 5000, n);
		bus(1'b1, wdog_pkg::CONFIG_OFFSET, 32'h0e);
		{e_run, e_on} = {1, 1};
		$display("test disable done");
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
		repeat (2000) @(posedge clk);
		for (int m = 0; m < 3; m++) begin
			{stp, idl, slp} <= 3'h4 >> m;
			repeat (1500) @(posedge clk);
		end
		{stp, idl, slp} <= 3'h0;
		wait_for(1'b0, 5000);
		check_in("resume", 1050, 2120, n);
		$display("test pause done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		{e_act, e_per} = {1, 0};
		tap <= 1'b0;
		slow <= 1'b1;
		chk_state();
		bus(1'b1, wdog_pkg::CONFIG_OFFSET, 32'h0f);
		e_per = 3;
		bus(1'b1, wdog_pkg::CODE_OFFSET, wdog_pkg::CLEAR_CODE);
		wait_for(1'b1, 5000);
		check_in("reset delay", 3060, 4110, n);
		n = 0;
		while (req === 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check_in("reset length", wdog_pkg::RST_CYCLES, wdog_pkg::RST_CYCLES, n);
		bus(1'b0, wdog_pkg::STATUS_OFFSET, 32'h0);
		check("status", 32'h2, {30'h0, rd[1:0]});
		check("resets", 1, nres);
		$display("test reset action done");
		final_report();
	end
endmodule : wdog_timer_control_test
bind wdog_timer_control wdog_timer_control_monitor u_mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .STOP_MODE(STOP_MODE),
	.IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE), .HRDATA(HRDATA), .WDOG_RESET_REQ(WDOG_RESET_REQ),
	.WDOG_IRQ(WDOG_IRQ));
`default_nettype wire
